// >>> rtl/tbl_boot_loader.sv
// tile boot loader: straps, pll setting, boot source select, image load and check
// Operation
// - clock straps pick pll ratio 40, 16, 8 or 4 with od 1, r 0
// - core = osc*(f+1)/2/(r+1)/(od+1); f, r, od within range, vco 260 MHz-1.3 GHz
// - pull-downs while in reset; boot begins 15 us after release
// - secure boot bit forces load from otp address 0, boot straps ignored
// - three boot straps pick qspi, spi, slave, both slave or link boot
// - image is word count, program words, crc; skip value bypasses check
// - count and crc arrive least significant byte first
// - program written from lowest ram address; execution starts there
// - reflected crc 0xEDB88320, start all ones, inverted residue compared
// - quad master drives select, data line 0 during the command, clock at core/8
// - masters send read command and zero 24-bit address, mode 0/0
// - quad bytes arrive low nibble first
// - single spi master clock is core/160 on four pins
// - spi master bytes arrive lsb first
// - spi slave accepts modes 0/0 and 1/1, lsb first
// - link enabled 2 us after boot start, pull-downs off, tx low only when boot straps pick link
// - link: ack destination, image, end token, send end unless the ack destination is the no-ack value, free, jump
// - tile one boots over link unless boot straps pick both slave or the secure boot bit is set
`timescale 1ns/1ps
module tbl_boot_loader
    import tbl_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // straps and security
    input  wire logic [1:0]  CLOCK_MODE,
    input  wire logic        BOOT_SELECT_BIT0,
    input  wire logic        BOOT_SELECT_BIT1,
    input  wire logic        BOOT_SELECT_BIT2,
    input  wire logic        TILE_ONE,
    input  wire logic        SECURE_BOOT,
    // pll setting
    output logic      [11:0] PLL_F,
    output logic      [5:0]  PLL_R,
    output logic      [2:0]  PLL_OUTPUT_DIVIDER,
    output logic      [5:0]  PLL_RATIO,
    // pins
    output logic             GPIO_PULLDOWN_EN,
    output logic             SPI_SS_N,
    output logic             SPI_SCLK,
    output logic             SPI_MOSI,
    input  wire logic        SPI_MISO,
    input  wire logic [3:0]  QUAD_DATA_LINES_I,
    output logic      [3:0]  QUAD_DATA_LINES_O,
    output logic      [3:0]  QUAD_DATA_LINES_OE,
    input  wire logic        SLV_SS_N,
    input  wire logic        SLV_SCLK,
    input  wire logic        SLV_MOSI,
    // link
    output logic             LINK_ENABLE,
    output logic             LINK_ZERO_EN,
    output logic             LINK_PULLDOWN_EN,
    output logic             CHANEND0_ALLOC,
    input  wire logic        LINK_RX_VALID,
    input  wire logic        LINK_RX_CTRL,
    input  wire logic [7:0]  LINK_RX_DATA,
    output logic             LINK_TX_VALID,
    output logic             LINK_TX_CTRL,
    output logic      [7:0]  LINK_TX_DATA,
    output logic      [31:0] LINK_TX_DEST,
    input  wire logic        LINK_TX_READY,
    // otp
    output logic             OTP_RD,
    output logic      [10:0] OTP_ADDR,
    input  wire logic [31:0] OTP_RDATA,
    // ram and start
    output logic             RAM_WE,
    output logic      [15:0] RAM_ADDR,
    output logic      [31:0] RAM_WDATA,
    output logic             BOOT_RUN,
    output logic             BOOT_HALTED,
    output logic      [31:0] BOOT_START_PC
);
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    tbl_state_t  st_q;
    tbl_src_t    src_q;
    tbl_img_t    img_q;
    logic [15:0] cnt_q;
    logic [1:0]  mode_s1_q, mode_s2_q;
    logic [5:0]  sel_s1_q, sel_s2_q;
    logic [2:0]  sel;
    logic [1:0]  lane_q;
    logic [31:0] word_q, asm_w;
    logic [31:0] words_q, crc_q, ack_q;
    logic [15:0] addr_q;
    logic        byte_v;
    logic [7:0]  byte_d;
    logic        start_q;
    logic [2:0]  ss_s1_q, ss_s2_q;
    logic        slv_clk_d_q;
    logic [7:0]  slv_sh_q;
    logic [2:0]  slv_bit_q;
    logic        slv_v_q;
    logic [1:0]  otp_ph_q;
    logic [31:0] otp_w_q;
    logic        otp_v;
    logic        load_done;
    tbl_spi_if   spi ();

    ////////////////////////////////////////////////////////////////////////
    // strap synchronisers; values are caught once the start-up delay ends
    always_ff @(posedge CLK) begin
        mode_s1_q <= CLOCK_MODE;
        mode_s2_q <= mode_s1_q;
        sel_s1_q  <= {TILE_ONE, SECURE_BOOT, BOOT_SELECT_BIT2, BOOT_SELECT_BIT1,
                      BOOT_SELECT_BIT0, 1'b0};
        sel_s2_q  <= sel_s1_q;
        ss_s1_q   <= {SLV_SS_N, SLV_SCLK, SLV_MOSI};
        ss_s2_q   <= ss_s1_q;
    end
    assign sel = sel_s2_q[3:1];

    // boot ratio held after the delay; software may reprogram the pll later
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PLL_F              <= PLL_F_X40;
            PLL_R              <= PLL_R_BOOT;
            PLL_OUTPUT_DIVIDER <= PLL_OD_BOOT;
            PLL_RATIO          <= 6'd40;
        end else if (st_q == ST_WAIT) begin
            PLL_R              <= PLL_R_BOOT;
            PLL_OUTPUT_DIVIDER <= PLL_OD_BOOT;
            case (mode_s2_q)
                2'b00: begin PLL_F <= PLL_F_X40; PLL_RATIO <= 6'd40; end
                2'b11: begin PLL_F <= PLL_F_X16; PLL_RATIO <= 6'd16; end
                2'b10: begin PLL_F <= PLL_F_X8;  PLL_RATIO <= 6'd8;  end
                default: begin PLL_F <= PLL_F_X4; PLL_RATIO <= 6'd4; end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boot sequence
    always_ff @(posedge CLK) begin
        start_q <= 1'b0;
        if (RESET) begin
            st_q  <= ST_WAIT;
            src_q <= SRC_OTP;
            cnt_q <= 16'h0000;
        end else begin
            case (st_q)
                ST_WAIT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(BOOT_DELAY_CYC - 1)) begin
                        cnt_q <= 16'h0000;
                        st_q  <= ST_LOAD;
                        if (sel_s2_q[4])
                            src_q <= SRC_OTP;
                        else if (sel == SEL_LINK || (sel_s2_q[5] && sel != SEL_BOTH_SLAVE)) begin
                            src_q <= SRC_LINK;
                            st_q  <= ST_LINK_WAIT;
                        end else if (sel[2:1] == 2'b01)
                            src_q <= SRC_SLAVE;
                        else begin
                            src_q   <= sel[1:0] == SEL_QSPI ? SRC_QSPI : SRC_SPI;
                            start_q <= 1'b1;
                        end
                    end
                end
                ST_LINK_WAIT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(LINK_DELAY_CYC - 1))
                        st_q <= ST_LINK_ACK;
                end
                ST_LINK_ACK:
                    if (LINK_RX_VALID && !LINK_RX_CTRL && lane_q == 2'h3)
                        st_q <= ST_LOAD;
                ST_LOAD:
                    if (load_done) begin
                        if (asm_w != CRC_SKIP && asm_w != ~crc_q)
                            st_q <= ST_HALT;
                        else
                            st_q <= (src_q == SRC_LINK) ? ST_LINK_END : ST_RUN;
                    end
                ST_LINK_END:
                    if (LINK_RX_VALID && LINK_RX_CTRL && LINK_RX_DATA == TOKEN_END)
                        st_q <= (ack_q == NO_ACK_DEST) ? ST_RUN : ST_LINK_TX;
                ST_LINK_TX:
                    if (LINK_TX_READY)
                        st_q <= ST_RUN;
                ST_RUN:  st_q <= ST_RUN;
                ST_HALT: st_q <= ST_HALT;
                default: st_q <= ST_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // spi slave: both supported modes sample on the rising edge
    always_ff @(posedge CLK) begin
        slv_v_q     <= 1'b0;
        slv_clk_d_q <= ss_s2_q[1];
        if (RESET || ss_s2_q[2]) begin
            slv_bit_q <= 3'h0;
        end else if (ss_s2_q[1] && !slv_clk_d_q) begin
            slv_sh_q  <= {ss_s2_q[0], slv_sh_q[7:1]};
            slv_bit_q <= slv_bit_q + 3'h1;
            slv_v_q   <= (slv_bit_q == 3'h7);
        end
    end

    // otp reader: one word per read, handed on as four bytes low lane first
    always_ff @(posedge CLK) begin
        if (RESET || st_q != ST_LOAD || src_q != SRC_OTP) begin
            otp_ph_q <= 2'h0;
            OTP_ADDR <= OTP_BASE;
        end else if (otp_ph_q == 2'h1) begin
            otp_w_q  <= OTP_RDATA;
            otp_ph_q <= 2'h2;
        end else if (otp_ph_q == 2'h2) begin
            otp_w_q <= otp_w_q >> 8;
            if (lane_q == 2'h3) begin
                otp_ph_q <= 2'h0;
                OTP_ADDR <= OTP_ADDR + 11'h001;
            end
        end else begin
            otp_ph_q <= 2'h1;
        end
    end
    assign OTP_RD = (st_q == ST_LOAD) && (src_q == SRC_OTP) && (otp_ph_q == 2'h0);
    assign otp_v  = (otp_ph_q == 2'h2);

    // byte source mux
    always_comb begin
        case (src_q)
            SRC_QSPI, SRC_SPI: begin byte_v = spi.byte_valid; byte_d = spi.byte_data; end
            SRC_SLAVE: begin byte_v = slv_v_q; byte_d = slv_sh_q; end
            SRC_LINK: begin byte_v = LINK_RX_VALID && !LINK_RX_CTRL; byte_d = LINK_RX_DATA; end
            default: begin byte_v = otp_v; byte_d = otp_w_q[7:0]; end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // word assembly, little endian
    assign asm_w     = {byte_d, word_q[31:8]};
    assign load_done = byte_v && lane_q == 2'h3 && img_q == IMG_CRC;

    always_ff @(posedge CLK) begin
        if (RESET || st_q == ST_WAIT || st_q == ST_LINK_WAIT) begin
            lane_q <= 2'h0;
        end else if (byte_v && (st_q == ST_LOAD || st_q == ST_LINK_ACK)) begin
            lane_q <= lane_q + 2'h1;
            word_q <= asm_w;
        end
    end

    always_ff @(posedge CLK) begin
        RAM_WE <= 1'b0;
        if (RESET || st_q != ST_LOAD) begin
            if (RESET) begin
                RAM_ADDR  <= RAM_BASE;
                RAM_WDATA <= 32'h0;
            end
            if (RESET || st_q != ST_RUN) begin
                img_q  <= IMG_COUNT;
                crc_q  <= CRC_INIT;
                addr_q <= RAM_BASE;
            end
        end else if (byte_v) begin
            if (img_q != IMG_CRC)
                crc_q <= crc_byte(crc_q, byte_d);
            if (lane_q == 2'h3) begin
                case (img_q)
                    IMG_COUNT: begin
                        words_q <= asm_w;
                        img_q   <= (asm_w == 32'h0) ? IMG_CRC : IMG_PROG;
                    end
                    IMG_PROG: begin
                        RAM_WE    <= 1'b1;
                        RAM_ADDR  <= addr_q;
                        RAM_WDATA <= asm_w;
                        addr_q    <= addr_q + 16'h0001;
                        words_q   <= words_q - 32'h1;
                        if (words_q == 32'h1)
                            img_q <= IMG_CRC;
                    end
                    default: img_q <= IMG_CRC;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET)
            ack_q <= NO_ACK_DEST;
        else if (st_q == ST_LINK_ACK && LINK_RX_VALID && !LINK_RX_CTRL && lane_q == 2'h3)
            ack_q <= asm_w;
    end

    ////////////////////////////////////////////////////////////////////////
    // flash master
    assign spi.start = start_q;
    assign spi.quad  = (src_q == SRC_QSPI);
    assign spi.stop  = (st_q != ST_LOAD);

    tbl_spi_master u_flash (
        .clk   (CLK),
        .rst   (RESET),
        .bus   (spi),
        .ss_n  (SPI_SS_N),
        .sclk  (SPI_SCLK),
        .mosi  (SPI_MOSI),
        .miso  (SPI_MISO),
        .qd_i  (QUAD_DATA_LINES_I),
        .qd_o  (QUAD_DATA_LINES_O),
        .qd_oe (QUAD_DATA_LINES_OE)
    );

    // outputs
    assign GPIO_PULLDOWN_EN = RESET || (st_q == ST_WAIT);
    assign LINK_ENABLE      = (src_q == SRC_LINK) && st_q != ST_WAIT && st_q != ST_LINK_WAIT;
    assign LINK_PULLDOWN_EN = !LINK_ENABLE;
    assign LINK_ZERO_EN     = LINK_ENABLE && (sel == SEL_LINK);
    assign CHANEND0_ALLOC   = LINK_ENABLE && st_q != ST_RUN && st_q != ST_HALT;
    assign LINK_TX_VALID    = (st_q == ST_LINK_TX);
    assign LINK_TX_CTRL     = LINK_TX_VALID;
    assign LINK_TX_DATA     = LINK_TX_VALID ? TOKEN_END : 8'h00;
    assign LINK_TX_DEST     = ack_q;
    assign BOOT_RUN         = (st_q == ST_RUN);
    assign BOOT_HALTED      = (st_q == ST_HALT);
    assign BOOT_START_PC    = BOOT_PC;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_check_done;
        (st_q == ST_LOAD) && load_done;
    endsequence
    sequence s_bad_crc;
        s_check_done ##0 (asm_w != CRC_SKIP && asm_w != ~crc_q);
    endsequence

    property p_bad_crc_halts;
        @(posedge CLK) disable iff (RESET) s_bad_crc |=> BOOT_HALTED && !BOOT_RUN;
    endproperty
    a_bad_crc_halts: assert property (p_bad_crc_halts) else $error("bad crc not halted");

    property p_skip_runs;
        @(posedge CLK) disable iff (RESET)
            s_check_done ##0 (asm_w == CRC_SKIP) |=> !BOOT_HALTED;
    endproperty
    a_skip_runs: assert property (p_skip_runs) else $error("skip value halted boot");

    property p_pll_formula;
        @(posedge CLK) disable iff (RESET)
            st_q != ST_WAIT |-> (13'(PLL_F) + 13'h1) ==
                13'(PLL_RATIO) * 13'h2 * (13'(PLL_R) + 13'h1) * (13'(PLL_OUTPUT_DIVIDER) + 13'h1);
    endproperty
    a_pll_formula: assert property (p_pll_formula) else $error("pll setting off ratio");

    property p_ratio_straps;
        @(posedge CLK) disable iff (RESET)
            $fell(st_q == ST_WAIT) && mode_s2_q == 2'b00 |-> PLL_RATIO == 6'd40;
    endproperty
    a_ratio_straps: assert property (p_ratio_straps) else $error("wrong pll ratio");

    property p_boot_delay;
        @(posedge CLK) $fell(RESET) |-> (st_q == ST_WAIT) [*8];
    endproperty
    a_boot_delay: assert property (p_boot_delay) else $error("boot began too early");

    property p_secure_otp;
        @(posedge CLK) disable iff (RESET)
            $fell(st_q == ST_WAIT) && sel_s2_q[4] |-> src_q == SRC_OTP && OTP_ADDR == OTP_BASE;
    endproperty
    a_secure_otp: assert property (p_secure_otp) else $error("secure boot ignored");

    property p_link_late;
        @(posedge CLK) disable iff (RESET)
            $rose(st_q == ST_LINK_WAIT) |-> !LINK_ENABLE [*8];
    endproperty
    a_link_late: assert property (p_link_late) else $error("link enabled early");

    property p_first_word_base;
        @(posedge CLK) disable iff (RESET)
            RAM_WE && $past(img_q) == IMG_PROG && $past(addr_q) == RAM_BASE |-> RAM_ADDR == RAM_BASE;
    endproperty
    a_first_word_base: assert property (p_first_word_base) else $error("ram base wrong");

    property p_end_sent;
        @(posedge CLK) disable iff (RESET)
            LINK_TX_VALID |-> LINK_TX_CTRL && LINK_TX_DATA == TOKEN_END && ack_q != NO_ACK_DEST;
    endproperty
    a_end_sent: assert property (p_end_sent) else $error("bad end token send");
endmodule

// >>> rtl/tbl_pkg.sv
// shared constants and types of the tile boot loader
package tbl_pkg;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          BOOT_DELAY_NS    = 15000;
    localparam int          BOOT_DELAY_CYC   = (BOOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LINK_DELAY_NS    = 2000;
    localparam int          LINK_DELAY_CYC   = (LINK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          QSPI_CORE_DIV    = 8;
    localparam int          SPI_CORE_DIV     = 160;
    localparam logic [7:0]  QSPI_HALF_CYC    = 8'(QSPI_CORE_DIV / 2);
    localparam logic [7:0]  SPI_HALF_CYC     = 8'(SPI_CORE_DIV / 2);
    localparam logic [7:0]  READ_CMD         = 8'h03;
    localparam logic [23:0] READ_ADDR        = 24'h000000;
    localparam logic [5:0]  CMD_BITS         = 6'h20;
    localparam logic [31:0] CRC_POLY         = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT         = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_SKIP         = 32'h0D15AB1E;
    localparam logic [31:0] NO_ACK_DEST      = 32'h0000FF02;
    localparam logic [7:0]  TOKEN_END        = 8'h01;
    localparam logic [15:0] RAM_BASE         = 16'h0000;
    localparam logic [31:0] BOOT_PC          = 32'h00000000;
    localparam logic [10:0] OTP_BASE         = 11'h000;
    localparam logic [11:0] PLL_F_X40        = 12'h09F;
    localparam logic [11:0] PLL_F_X16        = 12'h03F;
    localparam logic [11:0] PLL_F_X8         = 12'h01F;
    localparam logic [11:0] PLL_F_X4         = 12'h00F;
    localparam logic [5:0]  PLL_R_BOOT       = 6'h00;
    localparam logic [2:0]  PLL_OD_BOOT      = 3'h1;
    localparam logic [1:0]  SEL_QSPI         = 2'h0;
    localparam logic [1:0]  SEL_SPI          = 2'h1;
    localparam logic [2:0]  SEL_SLAVE        = 3'h2;
    localparam logic [2:0]  SEL_BOTH_SLAVE   = 3'h3;
    localparam logic [2:0]  SEL_LINK         = 3'h4;

    typedef enum {SRC_QSPI, SRC_SPI, SRC_SLAVE, SRC_LINK, SRC_OTP} tbl_src_t;
    typedef enum {ST_WAIT, ST_LINK_WAIT, ST_LINK_ACK, ST_LOAD, ST_LINK_END, ST_LINK_TX,
                  ST_RUN, ST_HALT} tbl_state_t;
    typedef enum {IMG_COUNT, IMG_PROG, IMG_CRC} tbl_img_t;
endpackage

// >>> rtl/tbl_spi_if.sv
// byte stream carrier between the loader and its flash reader
`timescale 1ns/1ps
interface tbl_spi_if;
    logic       start;
    logic       quad;
    logic       stop;
    logic       byte_valid;
    logic [7:0] byte_data;
    modport loader (output start, output quad, output stop, input byte_valid, input byte_data);
    modport reader (input start, input quad, input stop, output byte_valid, output byte_data);
endinterface

// >>> rtl/tbl_spi_master.sv
// flash reader: single or quad spi master, mode 0/0, lsb or low nibble first
`timescale 1ns/1ps
module tbl_spi_master
    import tbl_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // loader side
    tbl_spi_if.reader       bus,
    // pins
    output logic            ss_n,
    output logic            sclk,
    output logic            mosi,
    input  wire logic       miso,
    input  wire logic [3:0] qd_i,
    output logic      [3:0] qd_o,
    output logic      [3:0] qd_oe
);
    typedef enum {SM_IDLE, SM_CMD, SM_DATA} tbl_sm_t;
    tbl_sm_t     st_q;
    logic [7:0]  div_q;
    logic [5:0]  bit_q;
    logic [31:0] cmd_q;
    logic [7:0]  sh_q;
    logic [4:0]  miso_s1_q, miso_s2_q;
    logic        quad_q;
    logic        byte_v_q;
    logic        fall;

    ////////////////////////////////////////////////////////////////////////
    assign fall = sclk && (div_q == 8'h01);

    always_ff @(posedge clk) begin
        miso_s1_q <= {qd_i, miso};
        miso_s2_q <= miso_s1_q;
    end

    always_ff @(posedge clk) begin
        if (rst || bus.stop) begin
            st_q  <= SM_IDLE;
            div_q <= 8'h00;
            sclk  <= 1'b0;
            bit_q <= 6'h00;
        end else if (st_q == SM_IDLE) begin
            if (bus.start) begin
                st_q   <= SM_CMD;
                quad_q <= bus.quad;
                cmd_q  <= {READ_CMD, READ_ADDR};
                div_q  <= bus.quad ? QSPI_HALF_CYC : SPI_HALF_CYC;
                bit_q  <= 6'h00;
            end
        end else begin
            // one core/8 or core/160 serial clock, polarity 0
            div_q <= (div_q == 8'h01) ? (quad_q ? QSPI_HALF_CYC : SPI_HALF_CYC)
                                      : div_q - 8'h01;
            if (div_q == 8'h01)
                sclk <= ~sclk;
            if (fall && st_q == SM_CMD) begin
                cmd_q <= {cmd_q[30:0], 1'b0};
                bit_q <= bit_q + 6'h01;
                if (bit_q == CMD_BITS - 6'h01) begin
                    st_q  <= SM_DATA;
                    bit_q <= 6'h00;
                end
            end else if (fall) begin
                bit_q <= (bit_q == (quad_q ? 6'h01 : 6'h07)) ? 6'h00 : bit_q + 6'h01;
            end
        end
    end

    // sampled late in the high phase: the synchroniser costs two cycles
    always_ff @(posedge clk) begin
        byte_v_q <= 1'b0;
        if (rst) begin
            sh_q <= 8'h00;
        end else if (fall && st_q == SM_DATA) begin
            if (quad_q) begin
                sh_q <= {miso_s2_q[4:1], sh_q[7:4]};
                byte_v_q <= (bit_q == 6'h01);
            end else begin
                sh_q <= {miso_s2_q[0], sh_q[7:1]};
                byte_v_q <= (bit_q == 6'h07);
            end
        end
    end

    assign bus.byte_valid = byte_v_q;
    assign bus.byte_data  = sh_q;
    assign ss_n  = (st_q == SM_IDLE);
    assign mosi  = cmd_q[31];
    assign qd_o  = {3'h0, cmd_q[31]};
    assign qd_oe = {3'h0, (st_q == SM_CMD) && quad_q};

    property p_cmd_mode0;
        @(posedge clk) disable iff (rst) (st_q == SM_IDLE) |-> !sclk;
    endproperty
    a_cmd_mode0: assert property (p_cmd_mode0) else $error("sclk not idle low");
endmodule

// >>> tb/tbl_flash_model.sv
// quad flash partner: answers the read command with a fixed image
`timescale 1ns/1ps
module tbl_flash_model
    import tbl_pkg::*;
(
    // flash pins
    input  wire logic       ss_n,
    input  wire logic       sclk,
    output logic      [3:0] qd
);
    logic [7:0] img [12];
    int         rise_cnt;
    initial begin
        img = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h07, 8'h1E, 8'hC3, 8'hA5,
                8'h1E, 8'hAB, 8'h15, 8'h0D};
        qd = 4'hA;
    end
    always @(posedge sclk or posedge ss_n) rise_cnt <= ss_n ? 0 : rise_cnt + 1;
    // idle lines toggle so a stale nibble cannot pass as data
    always @(negedge sclk or posedge ss_n) begin
        if (!ss_n && rise_cnt >= 32 && rise_cnt < 56) begin
            qd <= rise_cnt[0] ? img[(rise_cnt - 32) / 2][7:4] : img[(rise_cnt - 32) / 2][3:0];
        end else begin
            qd <= ~qd;
        end
    end
endmodule

// >>> tb/tile_boot_loader_tb_top.sv
// bench: strap decode, quad flash boot, link boot with crc mismatch
`timescale 1ns/1ps
module tile_boot_loader_tb_top;
    import tbl_pkg::*;
    logic CLK = 0, RESET = 1, B0 = 0, B1 = 0, B2 = 0, RXV = 0, RXC = 0;
    logic T1 = 0, SEC = 0, TXR = 1;
    logic [1:0] CLOCK_MODE = 2'h0;
    logic [7:0] RXD = 8'h00;
    logic [3:0] qd, QO, QOE;
    logic [11:0] PLL_F;
    logic [5:0] PLL_RATIO;
    logic SS_N, SCLK, PD, LEN, LPD, CH0, WE, RUN, HALT;
    logic [15:0] RAM_ADDR;
    logic [31:0] RAM_WDATA, PC;
    int bad_count = 0, num_checks = 0;
    initial forever #5 CLK = ~CLK;
    tbl_flash_model flash (.ss_n(SS_N), .sclk(SCLK), .qd(qd));
    tbl_boot_loader uut (.CLK(CLK), .RESET(RESET), .CLOCK_MODE(CLOCK_MODE),
        .BOOT_SELECT_BIT0(B0), .BOOT_SELECT_BIT1(B1), .BOOT_SELECT_BIT2(B2),
        .TILE_ONE(T1), .SECURE_BOOT(SEC), .PLL_F(PLL_F), .PLL_R(), .PLL_OUTPUT_DIVIDER(),
        .PLL_RATIO(PLL_RATIO), .GPIO_PULLDOWN_EN(PD), .SPI_SS_N(SS_N), .SPI_SCLK(SCLK),
        .SPI_MOSI(), .SPI_MISO(1'b0), .QUAD_DATA_LINES_I((QOE & QO) | (~QOE & qd)),
        .QUAD_DATA_LINES_O(QO), .QUAD_DATA_LINES_OE(QOE), .SLV_SS_N(1'b1), .SLV_SCLK(1'b0),
        .SLV_MOSI(1'b0), .LINK_ENABLE(LEN), .LINK_ZERO_EN(), .LINK_PULLDOWN_EN(LPD),
        .CHANEND0_ALLOC(CH0), .LINK_RX_VALID(RXV), .LINK_RX_CTRL(RXC), .LINK_RX_DATA(RXD),
        .LINK_TX_VALID(), .LINK_TX_CTRL(), .LINK_TX_DATA(), .LINK_TX_DEST(),
        .LINK_TX_READY(TXR), .OTP_RD(), .OTP_ADDR(), .OTP_RDATA(32'h00000000),
        .RAM_WE(WE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .BOOT_RUN(RUN),
        .BOOT_HALTED(HALT), .BOOT_START_PC(PC));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // straps are set with reset and then left alone
    task rst(input logic [1:0] md, input logic b2);
        @(posedge CLK);
        CLOCK_MODE <= md;
        B2 <= b2;
        RESET <= 1;
        repeat (12) @(posedge CLK);
        RESET <= 0;
    endtask
    task snd(input logic c, input logic [7:0] d);
        @(posedge CLK);
        RXV <= 1;
        RXC <= c;
        RXD <= d;
        @(posedge CLK);
        RXV <= 0;
    endtask
    localparam logic [1:0]  MD [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    localparam logic [5:0]  RT [4] = '{6'd40, 6'd16, 6'd8, 6'd4};
    localparam logic [11:0] FV [4] = '{PLL_F_X40, PLL_F_X16, PLL_F_X8, PLL_F_X4};
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            rst(MD[i], 1'b0);
            repeat (6) @(negedge CLK);
            chk("pulldown", 1, PD);
            chk("ratio", RT[i], PLL_RATIO);
            chk("pll_f", FV[i], PLL_F);
        end
        for (int i = 0; i < 3000 && WE !== 1'b1; i++) @(negedge CLK);
        chk("ram_addr", RAM_BASE, RAM_ADDR);
        chk("ram_data", 32'hA5C31E07, RAM_WDATA);
        for (int i = 0; i < 500 && RUN !== 1'b1; i++) @(negedge CLK);
        chk("run", 1, RUN);
        chk("pc", BOOT_PC, PC);
        $display("test quad boot done");
        rst(2'h0, 1'b1);
        for (int i = 0; i < 3000 && LEN !== 1'b1; i++) @(negedge CLK);
        chk("link_pd", 0, LPD);
        chk("chanend", 1, CH0);
        for (int k = 0; k < 4; k++) snd(0, NO_ACK_DEST[8*k+:8]);
        for (int i = 0; i < 8; i++) snd(0, i < 4 ? 8'h00 : 8'h55);
        snd(1, TOKEN_END);
        for (int i = 0; i < 100 && HALT !== 1'b1; i++) @(negedge CLK);
        chk("halted", 1, HALT);
        chk("run", 0, RUN);
        $display("test link crc mismatch done");
        close_out();
    end
endmodule
